// ### rtl/tlo_pkg.sv
// ==========================================================
// Shared constants of the transmit line output block
package tlo_pkg;
  // System reference clock and loss-of-clock interval
  localparam int SYS_CLK_MHZ = 100;
  localparam int LOSS_TIME_US = 250;
  localparam int LOSS_CYCLES = LOSS_TIME_US * SYS_CLK_MHZ;
  localparam int CNT_W = 16;
  // Timing clock rates in kHz, low and high forms
  localparam int DS1_LF_KHZ = 1544;
  localparam int DS1_HF_KHZ = 6176;
  localparam int CEPT_LF_KHZ = 2048;
  localparam int CEPT_HF_KHZ = 8192;
  localparam int HF_DIV = DS1_HF_KHZ / DS1_LF_KHZ;
  // Strap level meaning DS1, and reset values
  localparam logic STRAP_DS1 = 1'h1;
  localparam logic RST_MODE_DS1 = 1'h1;
  localparam logic RST_LOST = 1'h0;
  localparam logic RST_RAIL = 1'h0;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  // Loss-of-clock monitor states
  typedef enum logic [1:0] {
    TLO_CLK_OK,
    TLO_CLK_LOST,
    TLO_CLK_RECOVER
  } tlo_mon_state_t;
endpackage : tlo_pkg

// ### rtl/tlo_sync2.sv
`timescale 1ns/1ps
// ==========================================================
// Two-stage synchroniser, one bit per lane
module tlo_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule : tlo_sync2

// ### rtl/tlo_line_out.sv
`timescale 1ns/1ps
// ==========================================================
// Link-side rails and line clock, on the timing clock
module tlo_line_out (
  input wire logic clk_link_in,
  input wire logic resetn_link_in,
  input wire logic high_freq_in,
  input wire logic single_rail_in,
  input wire logic line_clock_en_in,
  input wire logic framer_pos_in,
  input wire logic framer_neg_in,
  output logic tx_line_clock_out,
  output logic tx_pos_rail_out,
  output logic tx_neg_rail_out,
  output logic timing_toggle_out
);
  localparam logic [1:0] PH_LAST = 2'(tlo_pkg::HF_DIV - 1);
  localparam logic [1:0] PH_HALF = 2'(tlo_pkg::HF_DIV / 2 - 1);

  logic [1:0] phase;
  logic upd;

  // One line bit per timing edge, or per four at high rate
  assign upd = high_freq_in ? (phase == PH_LAST) : 1'h1;

  // Divider phase, parked on the wrap value in low-rate mode
  // Parking there makes the first high-rate edge a full line clock rise
  always_ff @(posedge clk_link_in or negedge resetn_link_in) begin
    if (!resetn_link_in) begin
      phase <= PH_LAST;
    end else begin
      phase <= high_freq_in ? phase + 2'h1 : PH_LAST;
    end
  end

  // Line clock rises on the wrap edge, half period high
  always_ff @(posedge clk_link_in or negedge resetn_link_in) begin
    if (!resetn_link_in) begin
      tx_line_clock_out <= 1'h0;
    end else begin
      tx_line_clock_out <= line_clock_en_in && high_freq_in &&
                           (phase == PH_LAST ||
                            (phase < PH_HALF && tx_line_clock_out));
    end
  end

  // Rails move on every timing edge at low rate, with the line clock rise at high rate
  always_ff @(posedge clk_link_in or negedge resetn_link_in) begin
    if (!resetn_link_in) begin
      tx_pos_rail_out <= tlo_pkg::RST_RAIL;
      tx_neg_rail_out <= tlo_pkg::RST_RAIL;
    end else begin
      if (upd) begin
        tx_pos_rail_out <= framer_pos_in;
      end
      if (single_rail_in) begin
        tx_neg_rail_out <= 1'h0;
      end else if (upd) begin
        tx_neg_rail_out <= framer_neg_in;
      end
    end
  end

  // Activity toggle for the loss monitor
  always_ff @(posedge clk_link_in or negedge resetn_link_in) begin
    if (!resetn_link_in) begin
      timing_toggle_out <= 1'h0;
    end else begin
      timing_toggle_out <= !timing_toggle_out;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_link_in); endclocking
  default disable iff (!resetn_link_in);

  rail_at_rise_a: assert property (
    (high_freq_in && $past(high_freq_in) && line_clock_en_in &&
     $past(line_clock_en_in) && $changed(tx_pos_rail_out))
    |-> $rose(tx_line_clock_out))
    else $error("positive rail moved without line clock rise");

  neg_rail_zero_a: assert property (
    single_rail_in |=> !tx_neg_rail_out)
    else $error("negative rail not zero in single-rail mode");

  low_rate_follow_a: assert property (
    (!high_freq_in && !single_rail_in) |=>
    (tx_pos_rail_out == $past(framer_pos_in) &&
     tx_neg_rail_out == $past(framer_neg_in)))
    else $error("rails do not follow framer data");

  line_clk_period_a: assert property (
    (high_freq_in && line_clock_en_in && $rose(tx_line_clock_out)) ##1
    (high_freq_in && line_clock_en_in)[*3] |=>
    ($past(tx_line_clock_out, 3) && !$past(tx_line_clock_out, 2) &&
     !$past(tx_line_clock_out) && tx_line_clock_out))
    else $error("line clock not a divide-by-four wave");

  single_rail_c: cover property (single_rail_in && $changed(tx_pos_rail_out));
  line_clk_c: cover property ($rose(tx_line_clock_out));
endmodule : tlo_line_out

// ### rtl/tlo_top.sv
`timescale 1ns/1ps
// ==========================================================
// Transmit line output and timing clock loss monitor

module tlo_top #(
  parameter int LOSS_CYCLES = tlo_pkg::LOSS_CYCLES,
  parameter int CNT_W = tlo_pkg::CNT_W
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic tx_timing_clock_in,
  input wire logic line_standard_select_in,
  input wire logic high_freq_sel_in,
  input wire logic single_rail_sel_in,
  input wire logic line_clock_en_in,
  input wire logic framer_pos_in,
  input wire logic framer_neg_in,
  output logic framing_mode_ds1_out,
  output logic tx_timing_clock_lost_out,
  output logic tx_line_clock_out,
  output logic tx_pos_rail_out,
  output logic tx_neg_rail_out
);
  // ==========================================================
  // Declarations
  localparam logic [CNT_W-1:0] LOSS_LAST = CNT_W'(LOSS_CYCLES - 1);

  logic resetn_link;
  logic [2:0] link_ctrl;
  logic timing_toggle;
  logic [1:0] sys_sync;
  logic strap_sync;
  logic toggle_sync;
  logic toggle_last;
  logic edge_seen;
  logic [1:0] strap_cnt;
  logic strap_taken;
  logic [CNT_W-1:0] idle_cnt;
  logic [CNT_W-1:0] run_cnt;
  logic idle_done;
  logic run_done;
  tlo_pkg::tlo_mon_state_t mon_state;
  tlo_pkg::tlo_mon_state_t next_mon_state;

  // ==========================================================
  // Link domain reset and control crossings

  // Reset release aligned to the timing clock
  tlo_sync2 #(
    .W(1)
  ) u_link_rst (
    .clk_in(tx_timing_clock_in),
    .resetn_in(resetn_in),
    .d_in(1'h1),
    .q_out(resetn_link)
  );

  // Mode pins into the timing clock domain
  tlo_sync2 #(
    .W(3)
  ) u_link_ctrl (
    .clk_in(tx_timing_clock_in),
    .resetn_in(resetn_link),
    .d_in({line_clock_en_in, single_rail_sel_in, high_freq_sel_in}),
    .q_out(link_ctrl)
  );

  // ==========================================================
  // Line side datapath

  // Rails, line clock and activity toggle
  tlo_line_out u_line_out (
    .clk_link_in(tx_timing_clock_in),
    .resetn_link_in(resetn_link),
    .high_freq_in(link_ctrl[0]),
    .single_rail_in(link_ctrl[1]),
    .line_clock_en_in(link_ctrl[2]),
    .framer_pos_in(framer_pos_in),
    .framer_neg_in(framer_neg_in),
    .tx_line_clock_out(tx_line_clock_out),
    .tx_pos_rail_out(tx_pos_rail_out),
    .tx_neg_rail_out(tx_neg_rail_out),
    .timing_toggle_out(timing_toggle)
  );

  // ==========================================================
  // System domain crossings

  // Strap pin and activity toggle onto the system clock
  tlo_sync2 #(
    .W(2)
  ) u_sys_sync (
    .clk_in(clk_sys_in),
    .resetn_in(resetn_in),
    .d_in({timing_toggle, line_standard_select_in}),
    .q_out(sys_sync)
  );

  assign strap_sync = sys_sync[0];
  assign toggle_sync = sys_sync[1];

  // Delayed toggle for edge detection
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      toggle_last <= 1'h0;
    end else begin
      toggle_last <= toggle_sync;
    end
  end

  // Any change means the timing clock ticked
  assign edge_seen = toggle_sync ^ toggle_last;

  // ==========================================================
  // Default framing mode from the strap

  // Wait until the strap has passed the synchroniser
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strap_cnt <= 2'h0;
      strap_taken <= 1'h0;
    end else if (!strap_taken) begin
      if (strap_cnt == tlo_pkg::STRAP_SETTLE) begin
        strap_taken <= 1'h1;
      end else begin
        strap_cnt <= strap_cnt + 2'h1;
      end
    end
  end

  // Capture the strap once, then hold
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      framing_mode_ds1_out <= tlo_pkg::RST_MODE_DS1;
    end else if (!strap_taken && strap_cnt == tlo_pkg::STRAP_SETTLE) begin
      framing_mode_ds1_out <= (strap_sync == tlo_pkg::STRAP_DS1);
    end
  end

  // ==========================================================
  // Loss-of-clock monitor

  // Cycles since the last timing edge, saturating
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      idle_cnt <= '0;
    end else if (edge_seen) begin
      idle_cnt <= '0;
    end else if (!idle_done) begin
      idle_cnt <= idle_cnt + CNT_W'(1);
    end
  end

  assign idle_done = (idle_cnt == LOSS_LAST);
  assign run_done = (run_cnt == LOSS_LAST);

  // Cycles since recovery began
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      run_cnt <= '0;
    end else if (mon_state != tlo_pkg::TLO_CLK_RECOVER) begin
      run_cnt <= '0;
    end else if (!run_done) begin
      run_cnt <= run_cnt + CNT_W'(1);
    end
  end

  // Next monitor state
  always_comb begin
    next_mon_state = mon_state;
    case (mon_state)
      tlo_pkg::TLO_CLK_OK: begin
        if (!edge_seen && idle_done) begin
          next_mon_state = tlo_pkg::TLO_CLK_LOST;
        end
      end
      tlo_pkg::TLO_CLK_LOST: begin
        if (edge_seen) begin
          next_mon_state = tlo_pkg::TLO_CLK_RECOVER;
        end
      end
      tlo_pkg::TLO_CLK_RECOVER: begin
        if (!edge_seen && idle_done) begin
          next_mon_state = tlo_pkg::TLO_CLK_LOST;
        end else if (run_done) begin
          next_mon_state = tlo_pkg::TLO_CLK_OK;
        end
      end
      default: begin
        next_mon_state = tlo_pkg::TLO_CLK_OK;
      end
    endcase
  end

  // Monitor state register
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mon_state <= tlo_pkg::TLO_CLK_OK;
    end else begin
      mon_state <= next_mon_state;
    end
  end

  // Loss flag high in lost and recovering states
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_timing_clock_lost_out <= tlo_pkg::RST_LOST;
    end else begin
      tx_timing_clock_lost_out <= (next_mon_state != tlo_pkg::TLO_CLK_OK);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  loss_detect_a: assert property (
    (mon_state != tlo_pkg::TLO_CLK_LOST && !edge_seen && idle_done)
    |=> tx_timing_clock_lost_out)
    else $error("loss not flagged after idle interval");

  loss_cause_a: assert property (
    $rose(tx_timing_clock_lost_out) |->
    ($past(idle_cnt) == LOSS_LAST && !$past(edge_seen)))
    else $error("loss flagged before idle interval ended");

  recover_time_a: assert property (
    (mon_state == tlo_pkg::TLO_CLK_RECOVER && run_done &&
     !(idle_done && !edge_seen)) |=> !tx_timing_clock_lost_out)
    else $error("loss flag not cleared after recovery interval");

  recover_cause_a: assert property (
    $fell(tx_timing_clock_lost_out) |->
    ($past(mon_state) == tlo_pkg::TLO_CLK_RECOVER && $past(run_cnt) == LOSS_LAST))
    else $error("loss flag cleared early");

  lost_hold_a: assert property (
    (mon_state == tlo_pkg::TLO_CLK_LOST && !edge_seen) |=>
    (tx_timing_clock_lost_out && mon_state == tlo_pkg::TLO_CLK_LOST))
    else $error("loss flag dropped without clock edge");

  idle_restart_a: assert property (
    (edge_seen ##1 !edge_seen ##1 !edge_seen) |-> idle_cnt == CNT_W'(1))
    else $error("idle count not restarted by clock edge");

  strap_take_a: assert property (
    $rose(strap_taken) |->
    framing_mode_ds1_out == ($past(strap_sync) == tlo_pkg::STRAP_DS1))
    else $error("framing mode does not match strap");

  strap_hold_a: assert property (
    (strap_taken && $past(strap_taken)) |-> $stable(framing_mode_ds1_out))
    else $error("framing mode changed after capture");

  // ==========================================================
  // Monitor step and strap wait checks

  recover_entry_a: assert property (
    (mon_state == tlo_pkg::TLO_CLK_LOST && edge_seen) |=>
    (mon_state == tlo_pkg::TLO_CLK_RECOVER && run_cnt == '0 && tx_timing_clock_lost_out))
    else $error("recovery not entered on first clock edge");

  recover_hold_a: assert property (
    (mon_state == tlo_pkg::TLO_CLK_RECOVER && !run_done) |=> tx_timing_clock_lost_out)
    else $error("loss flag dropped before recovery interval");

  ok_edge_a: assert property (
    (mon_state == tlo_pkg::TLO_CLK_OK && edge_seen) |=>
    (mon_state == tlo_pkg::TLO_CLK_OK && !tx_timing_clock_lost_out))
    else $error("loss flagged while clock toggles");

  idle_early_a: assert property (
    (mon_state == tlo_pkg::TLO_CLK_OK && !idle_done) |=> !tx_timing_clock_lost_out)
    else $error("loss flagged before idle interval");

  run_step_a: assert property (
    (mon_state == tlo_pkg::TLO_CLK_RECOVER && next_mon_state == tlo_pkg::TLO_CLK_RECOVER &&
     !run_done) |=> run_cnt == $past(run_cnt) + CNT_W'(1))
    else $error("recovery count did not advance");

  idle_step_a: assert property (
    (!edge_seen && !idle_done) |=> idle_cnt == $past(idle_cnt) + CNT_W'(1))
    else $error("idle count did not advance");

  strap_wait_a: assert property (
    !strap_taken |-> framing_mode_ds1_out == tlo_pkg::RST_MODE_DS1)
    else $error("framing mode left reset value before capture");

  loss_c: cover property ($rose(tx_timing_clock_lost_out));
  recover_c: cover property ($fell(tx_timing_clock_lost_out));
  cept_c: cover property ($rose(strap_taken) && !framing_mode_ds1_out);
endmodule : tlo_top

// ### tb/tlo_liu_model.sv
`timescale 1ns/1ps
// ==========================================================
// Line interface unit taking dual-rail NRZ from the channel
module tlo_liu_model (
  input wire logic tx_line_clock_in,
  input wire logic tx_pos_rail_in,
  input wire logic tx_neg_rail_in,
  output logic rx_pos_out,
  output logic rx_neg_out,
  output logic [15:0] rx_bits_out
);
  // Known state before the first bit
  initial begin
    rx_pos_out = 1'b0;
    rx_neg_out = 1'b0;
    rx_bits_out = 16'h0000;
  end

  // Mid-bit sampling, away from the rising edge where rails move
  always @(negedge tx_line_clock_in) begin
    rx_pos_out <= tx_pos_rail_in;
    rx_neg_out <= tx_neg_rail_in;
    rx_bits_out <= rx_bits_out + 16'h0001;
  end
endmodule : tlo_liu_model

// ### tb/tx_line_output_clock_monitor_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the line output and loss monitor
module tx_line_output_clock_monitor_tb_top;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic tclk = 1'b0;
  logic run_tclk = 1'b1;
  logic strap = 1'b1;
  logic hf = 1'b0;
  logic sr = 1'b0;
  logic lce = 1'b0;
  logic fpos = 1'b0;
  logic fneg = 1'b0;
  logic mode_ds1, lost, lclk, pos, neg, rx_pos, rx_neg;
  logic [15:0] rx_bits;
  int n_fail = 0;
  int samples_checked = 0;

  // System clock, 100 MHz
  always #5 clk_sys_in = ~clk_sys_in;

  // Timing clock, 48 ns, own phase, can be stopped low
  initial begin
    #3;
    forever #24 tclk = run_tclk ? ~tclk : 1'b0;
  end

  tlo_top #(.LOSS_CYCLES(40), .CNT_W(16)) tlo_top_i (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .tx_timing_clock_in(tclk),
    .line_standard_select_in(strap),
    .high_freq_sel_in(hf),
    .single_rail_sel_in(sr),
    .line_clock_en_in(lce),
    .framer_pos_in(fpos),
    .framer_neg_in(fneg),
    .framing_mode_ds1_out(mode_ds1),
    .tx_timing_clock_lost_out(lost),
    .tx_line_clock_out(lclk),
    .tx_pos_rail_out(pos),
    .tx_neg_rail_out(neg)
  );

  tlo_liu_model tlo_liu_model_i (
    .tx_line_clock_in(lclk),
    .tx_pos_rail_in(pos),
    .tx_neg_rail_in(neg),
    .rx_pos_out(rx_pos),
    .rx_neg_out(rx_neg),
    .rx_bits_out(rx_bits)
  );

  // ==========================================================
  // Shared helpers
  task automatic check(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic do_reset(input logic s);
    @(negedge clk_sys_in);
    resetn_in = 1'b0;
    strap = s;
    repeat (4) @(negedge clk_sys_in);
    resetn_in = 1'b1;
    repeat (8) @(negedge clk_sys_in);
  endtask : do_reset

  task automatic set_mode(input logic h, input logic s, input logic e);
    @(negedge tclk);
    hf = h;
    sr = s;
    lce = e;
    repeat (6) @(negedge tclk);
  endtask : set_mode

  task automatic send_bit(input logic p, input logic n);
    @(negedge tclk);
    fpos = p;
    fneg = n;
    @(posedge tclk);
    #1;
  endtask : send_bit

  // ==========================================================
  // Scenarios
  task automatic test_strap;
    do_reset(1'b0);
    check("mode cept", 1'b0, mode_ds1);
    @(negedge clk_sys_in);
    strap = 1'b1;
    repeat (6) @(negedge clk_sys_in);
    check("mode kept", 1'b0, mode_ds1);
    do_reset(1'b1);
    check("mode ds1", 1'b1, mode_ds1);
  endtask : test_strap

  task automatic test_loss;
    repeat (60) @(negedge clk_sys_in);
    check("lost running", 1'b0, lost);
    run_tclk = 1'b0;
    repeat (30) @(negedge clk_sys_in);
    check("lost early", 1'b0, lost);
    repeat (25) @(negedge clk_sys_in);
    check("lost set", 1'b1, lost);
    run_tclk = 1'b1;
    repeat (30) @(negedge clk_sys_in);
    check("lost held", 1'b1, lost);
    repeat (25) @(negedge clk_sys_in);
    check("lost clear", 1'b0, lost);
  endtask : test_loss

  task automatic test_low_rate;
    set_mode(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      send_bit(i[0], i[1]);
      check("low pos", i[0], pos);
      check("low neg", i[1], neg);
      check("low lclk", 1'b0, lclk);
    end
  endtask : test_low_rate

  task automatic test_high_rate;
    logic [15:0] n0;
    set_mode(1'b1, 1'b0, 1'b1);
    n0 = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      @(posedge lclk);
      if (i == 0) begin
        n0 = rx_bits;
      end
      @(negedge tclk);
      fpos = ~i[0];
      fneg = i[1];
      @(posedge lclk);
      #1;
      check("high pos", ~i[0], pos);
      check("high neg", i[1], neg);
      @(negedge lclk);
      #1;
      check("liu pos", ~i[0], rx_pos);
      check("liu neg", i[1], rx_neg);
    end
    check("liu count", 1'b1, rx_bits == n0 + 16'h0008);
  endtask : test_high_rate

  task automatic test_single;
    set_mode(1'b0, 1'b1, 1'b0);
    send_bit(1'b1, 1'b1);
    check("single pos", 1'b1, pos);
    check("single neg", 1'b0, neg);
    send_bit(1'b0, 1'b1);
    check("single pos", 1'b0, pos);
    check("single neg", 1'b0, neg);
  endtask : test_single

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    test_strap();
    test_loss();
    test_low_rate();
    test_high_rate();
    test_single();
    finish_test();
  end

  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
endmodule : tx_line_output_clock_monitor_tb_top
